/* verilog/udc_pkg.sv */
/*
  udc_pkg: constants and carrier types for the usb device control and
  interrupt block. assumes a 16-bit local cpu register port.
*/
package udc_pkg;
  localparam logic [15:0] UDC_BASE       = 16'h4000;
  localparam logic [15:0] UDC_SPAN       = 16'h0030;
  localparam logic [15:0] UDC_OFS_CTRL   = 16'h4000;
  localparam logic [15:0] UDC_OFS_EN_LO  = 16'h4002;
  localparam logic [15:0] UDC_OFS_ST_LO  = 16'h4004;
  localparam logic [15:0] UDC_OFS_EN_HI  = 16'h4006;
  localparam logic [15:0] UDC_OFS_ST_HI  = 16'h4008;

  localparam int CTL_CLK_GATE  = 7;
  localparam int CTL_ZLP       = 6;
  localparam int CTL_ENUM_EN   = 5;
  localparam int CTL_EP4_STALL = 4;
  localparam int CTL_EP3_STALL = 3;
  localparam int CTL_PIN_SEL   = 2;

  localparam int ST_SUSPEND = 7;
  localparam int ST_SOF     = 6;
  localparam int ST_EP4     = 4;
  localparam int ST_EP3     = 3;
  localparam int ST_EP2     = 2;
  localparam int ST_EP1     = 1;
  localparam int ST_UPPER   = 0;
  localparam int ST_TX_AE   = 1;
  localparam int ST_RX_AF   = 0;

  localparam logic [7:0] CTRL_WMASK  = 8'hfc;
  localparam logic [7:0] LO_MASK     = 8'hde;
  localparam logic [1:0] HI_MASK     = 2'h3;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] EN_LO_RESET = 8'h00;
  localparam logic [7:0] ST_LO_RESET = 8'h00;
  localparam logic [1:0] EN_HI_RESET = 2'h0;
  localparam logic [1:0] ST_HI_RESET = 2'h0;

  typedef enum logic [1:0] {
    UDC_TOK_IN_EP4  = 2'h0,
    UDC_TOK_OUT_EP3 = 2'h1,
    UDC_TOK_DESC    = 2'h2,
    UDC_TOK_OTHER   = 2'h3
  } udc_tok_kind_t;

  typedef enum logic [3:0] {
    UDC_RSP_DATA  = 4'h1,
    UDC_RSP_ZLP   = 4'h2,
    UDC_RSP_NAK   = 4'h4,
    UDC_RSP_STALL = 4'h8
  } udc_rsp_code_t;

  typedef struct packed {
    logic          valid;
    udc_tok_kind_t kind;
  } udc_token_t;

  typedef struct packed {
    logic          valid;
    udc_rsp_code_t code;
    logic          discard;
  } udc_resp_t;

  typedef struct packed {
    logic suspend;
    logic sof;
    logic ep4_sent;
    logic ep3_rcvd;
    logic ep2_read;
    logic ep1_written;
    logic tx_byte_sent;
    logic rx_byte_rcvd;
  } udc_events_t;
endpackage

/* verilog/udc_ctrl.sv */
/*
  udc_ctrl: control, response steering and interrupt flags of the usb
  device. assumes a protocol engine on the same clock hands over tokens
  and one-cycle event pulses, and that the clock gate cell sits outside.
*/
`timescale 1ns/1ps
// Summary of operation
// - decode 48-byte window at offset 4000h
// - control bit 7 gates the usb clock
// - bit 6 set, empty fifo: ack zlp
// - bit 6 clear, empty fifo: nak
// - bit 6 self-clears after zlp answer
// - bit 5 clear: nak descriptor reads
// - bit 4 set: stall bulk in reads
// - bit 3 set: stall and discard bulk writes
// - bit 2 routes gpio 7:4 to usb
// - enable bits let status flags interrupt
// - suspend request sets status bit 7
// - start of frame sets status bit 6
// - endpoint 4 packet sent sets bit 4
// - endpoint 3 packet sets bit 3, refuses more
// - endpoint 2 mailbox read sets bit 2
// - endpoint 1 mailbox write sets bit 1
// - flags clear on writing one only
// - status bit 0 shows any upper flag
// - upper enable bit 1 gates tx almost-empty
// - upper enable bit 0 gates rx almost-full
// - tx almost-empty when tx count equals threshold
module udc_ctrl
  import udc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [15:0]      cpu_addr_in,
  input  wire logic             cpu_cs_in,
  input  wire logic             cpu_wr_in,
  input  wire logic             cpu_rd_in,
  input  wire logic [15:0]      cpu_wdata_in,
  output logic      [15:0]      cpu_rdata_out,
  output logic                  cpu_hit_out,
  input  wire udc_token_t       token_in,
  input  wire logic             tx_empty_in,
  output udc_resp_t             resp_out,
  input  wire udc_events_t      events_in,
  input  wire logic [CNT_W-1:0] tx_count_in,
  input  wire logic [CNT_W-1:0] tx_thresh_in,
  input  wire logic [CNT_W-1:0] rx_count_in,
  input  wire logic [CNT_W-1:0] rx_thresh_in,
  output logic                  usb_clock_gate_out,
  output logic                  usb_pin_sel_out,
  output logic                  irq_out
);

  generate
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
      $error("udc_ctrl: CNT_W out of range");
    end
  endgenerate

  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ofs);
    addr_is = (a == ofs);
  endfunction

  logic [7:0] ctrl_q;
  logic [7:0] en_lo_q;
  logic [7:0] st_lo_q;
  logic [1:0] en_hi_q;
  logic [1:0] st_hi_q;
  logic       in_window;
  logic       wr_stb;
  logic       rd_stb;
  logic       usb_live;
  logic       zlp_sent;
  logic [7:0] lo_set;
  logic [1:0] hi_set;
  logic [7:0] lo_clr;
  logic [1:0] hi_clr;
  logic [7:0] lo_view;
  udc_resp_t  resp_d;
  udc_resp_t  resp_q;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  // only the low byte of the window is populated
  assign in_window = (cpu_addr_in >= UDC_BASE) && (cpu_addr_in < UDC_BASE + UDC_SPAN);
  assign wr_stb    = cpu_cs_in && cpu_wr_in && in_window;
  assign rd_stb    = cpu_cs_in && cpu_rd_in && in_window;
  assign cpu_hit_out = cpu_cs_in && in_window;

  // events are ignored while the usb clock is gated, since the engine is stopped
  assign usb_live = ctrl_q[CTL_CLK_GATE];
  assign usb_clock_gate_out = ctrl_q[CTL_CLK_GATE];
  assign usb_pin_sel_out    = ctrl_q[CTL_PIN_SEL];

  // token answer, stall ahead of all other outcomes
  always_comb begin
    resp_d         = '0;
    resp_d.code    = UDC_RSP_NAK;
    resp_d.valid   = token_in.valid && usb_live;
    case (token_in.kind)
      UDC_TOK_IN_EP4: begin
        if (ctrl_q[CTL_EP4_STALL]) begin
          resp_d.code = UDC_RSP_STALL;
        end else if (!tx_empty_in) begin
          resp_d.code = UDC_RSP_DATA;
        end else if (ctrl_q[CTL_ZLP]) begin
          resp_d.code = UDC_RSP_ZLP;
        end else begin
          resp_d.code = UDC_RSP_NAK;
        end
      end
      UDC_TOK_OUT_EP3: begin
        if (ctrl_q[CTL_EP3_STALL]) begin
          resp_d.code    = UDC_RSP_STALL;
          resp_d.discard = 1'b1;
        end else if (st_lo_q[ST_EP3]) begin
          resp_d.code    = UDC_RSP_NAK;
          resp_d.discard = 1'b1;
        end else begin
          resp_d.code = UDC_RSP_DATA;
        end
      end
      UDC_TOK_DESC: begin
        if (ctrl_q[CTL_ENUM_EN]) begin
          resp_d.code = UDC_RSP_DATA;
        end else begin
          resp_d.code = UDC_RSP_NAK;
        end
      end
      UDC_TOK_OTHER: begin
        resp_d.code = UDC_RSP_DATA;
      end
      default: begin
        resp_d.code = UDC_RSP_NAK;
      end
    endcase
  end

  assign zlp_sent = resp_d.valid && (resp_d.code == UDC_RSP_ZLP);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end
  assign resp_out = resp_q;

  // control register; a software write in the same cycle beats the self-clear
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_stb && addr_is(cpu_addr_in, UDC_OFS_CTRL)) begin
      ctrl_q <= cpu_wdata_in[7:0] & CTRL_WMASK;
    end else if (zlp_sent) begin
      ctrl_q[CTL_ZLP] <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      en_lo_q <= EN_LO_RESET;
      en_hi_q <= EN_HI_RESET;
    end else if (wr_stb) begin
      if (addr_is(cpu_addr_in, UDC_OFS_EN_LO)) begin
        en_lo_q <= cpu_wdata_in[7:0] & LO_MASK;
      end
      if (addr_is(cpu_addr_in, UDC_OFS_EN_HI)) begin
        en_hi_q <= cpu_wdata_in[1:0] & HI_MASK;
      end
    end
  end

  // event sources, qualified by the running usb clock
  always_comb begin
    lo_set              = 8'h00;
    lo_set[ST_SUSPEND]  = events_in.suspend && usb_live;
    lo_set[ST_SOF]      = events_in.sof && usb_live;
    lo_set[ST_EP4]      = events_in.ep4_sent && usb_live;
    lo_set[ST_EP3]      = events_in.ep3_rcvd && usb_live;
    lo_set[ST_EP2]      = events_in.ep2_read && usb_live;
    lo_set[ST_EP1]      = events_in.ep1_written && usb_live;
    hi_set              = 2'h0;
    hi_set[ST_TX_AE]    = events_in.tx_byte_sent && usb_live
                          && (tx_count_in == tx_thresh_in);
    hi_set[ST_RX_AF]    = events_in.rx_byte_rcvd && usb_live
                          && (rx_count_in == rx_thresh_in);
  end

  assign lo_clr = (wr_stb && addr_is(cpu_addr_in, UDC_OFS_ST_LO)) ?
                  (cpu_wdata_in[7:0] & LO_MASK) : 8'h00;
  assign hi_clr = (wr_stb && addr_is(cpu_addr_in, UDC_OFS_ST_HI)) ?
                  (cpu_wdata_in[1:0] & HI_MASK) : 2'h0;

  // set wins over a simultaneous clear so no event is lost
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_lo_q <= ST_LO_RESET;
    end else begin
      st_lo_q <= ((st_lo_q & ~lo_clr) | lo_set) & LO_MASK;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_hi_q <= ST_HI_RESET;
    end else begin
      st_hi_q <= (st_hi_q & ~hi_clr) | hi_set;
    end
  end

  always_comb begin
    lo_view           = st_lo_q;
    lo_view[ST_UPPER] = |st_hi_q;
  end

  // read data latched on the read strobe, unpopulated offsets read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (addr_is(cpu_addr_in, UDC_OFS_CTRL)) begin
      rdata_d[7:0] = ctrl_q;
    end else if (addr_is(cpu_addr_in, UDC_OFS_EN_LO)) begin
      rdata_d[7:0] = en_lo_q;
    end else if (addr_is(cpu_addr_in, UDC_OFS_ST_LO)) begin
      rdata_d[7:0] = lo_view;
    end else if (addr_is(cpu_addr_in, UDC_OFS_EN_HI)) begin
      rdata_d[1:0] = en_hi_q;
    end else if (addr_is(cpu_addr_in, UDC_OFS_ST_HI)) begin
      rdata_d[1:0] = st_hi_q;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 16'h0000;
    end else if (rd_stb) begin
      rdata_q <= rdata_d;
    end
  end
  assign cpu_rdata_out = rdata_q;

  // level interrupt; the upper summary bit is not itself an interrupt source
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(st_lo_q & en_lo_q & LO_MASK)
                 | (st_hi_q[ST_TX_AE] & en_hi_q[ST_TX_AE])
                 | (st_hi_q[ST_RX_AF] & en_hi_q[ST_RX_AF]);
    end
  end

endmodule

/* bench/udc_ctrl_monitor.sv */
/* udc_ctrl_monitor: port checks of udc_ctrl.
   assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
module udc_ctrl_monitor
  import udc_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        reset_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic        cpu_cs_in,
  input wire logic        cpu_wr_in,
  input wire logic [15:0] cpu_wdata_in,
  input wire logic        cpu_hit_out,
  input wire udc_token_t  token_in,
  input wire logic        tx_empty_in,
  input wire udc_resp_t   resp_out,
  input wire udc_events_t events_in,
  input wire logic        usb_clock_gate_out,
  input wire logic        usb_pin_sel_out,
  input wire logic        irq_out
);
  logic go;
  logic quiet;
  assign go = token_in.valid && usb_clock_gate_out;
  // no write, no event: flags and enables cannot move
  assign quiet = !cpu_wr_in && events_in == '0;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_hit; cpu_hit_out == (cpu_cs_in && cpu_addr_in - UDC_BASE < UDC_SPAN); endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_go; go |=> resp_out.valid; endproperty
  a_go: assert property (p_go) else $error("no answer");
  property p_idle; !go |=> !resp_out.valid; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_in4; go && token_in.kind == UDC_TOK_IN_EP4 |=> resp_out.code == UDC_RSP_STALL
    || (resp_out.code == UDC_RSP_DATA) == !$past(tx_empty_in); endproperty
  a_in4: assert property (p_in4) else $error("in answer");
  property p_ep3; go && token_in.kind == UDC_TOK_OUT_EP3
    |=> resp_out.discard == (resp_out.code != UDC_RSP_DATA); endproperty
  a_ep3: assert property (p_ep3) else $error("out discard");
  property p_desc; go && token_in.kind == UDC_TOK_DESC
    |=> resp_out.code inside {UDC_RSP_DATA, UDC_RSP_NAK}; endproperty
  a_desc: assert property (p_desc) else $error("desc answer");
  property p_irq; quiet ##1 quiet |=> $stable(irq_out); endproperty
  a_irq: assert property (p_irq) else $error("irq moved");
  property p_ctl; cpu_cs_in && cpu_wr_in && cpu_addr_in == UDC_OFS_CTRL
    |=> usb_clock_gate_out == $past(cpu_wdata_in[7])
    && usb_pin_sel_out == $past(cpu_wdata_in[2]); endproperty
  a_ctl: assert property (p_ctl) else $error("gate or pin");
endmodule
bind udc_ctrl udc_ctrl_monitor i_mon (.*);

/* bench/udc_host_model.sv */
/* udc_host_model: usb host side, issues tokens and event pulses.
   assumes the bench calls pulse; drives at the falling edge. */
`timescale 1ns/1ps
module udc_host_model
  import udc_pkg::*;
(
  input  wire logic  clock_in,
  output udc_token_t  token_out,
  output udc_events_t events_out
);
  initial begin
    token_out = '0;
    events_out = '0;
  end
  // one cycle wide, so the device takes each exactly once
  task automatic pulse(input udc_token_t t, input udc_events_t e);
    @(negedge clock_in);
    token_out = t;
    events_out = e;
    @(negedge clock_in);
    token_out = '0;
    events_out = '0;
  endtask
endmodule

/* bench/udc_ctrl_tb.sv */
/* udc_ctrl_tb: register, token and flag tests of udc_ctrl.
   assumes udc_pkg, the design, monitor and host model compiled first. */
`timescale 1ns/1ps
module udc_ctrl_tb
  import udc_pkg::*;
;
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [15:0] cpu_addr_in = 16'h0000;
  logic [15:0] cpu_wdata_in = 16'h0000;
  logic        cpu_cs_in = 1'b0;
  logic        cpu_wr_in = 1'b0;
  logic        cpu_rd_in = 1'b0;
  logic        tx_empty_in = 1'b1;
  logic [6:0]  tx_count_in = 7'h05;
  logic [6:0]  tx_thresh_in = 7'h05;
  logic [6:0]  rx_count_in = 7'h04;
  logic [6:0]  rx_thresh_in = 7'h05;
  logic [15:0] cpu_rdata_out;
  logic        cpu_hit_out;
  logic        usb_clock_gate_out;
  logic        usb_pin_sel_out;
  logic        irq_out;
  udc_token_t  token_in;
  udc_resp_t   resp_out;
  udc_events_t events_in;
  int          errors = 0;
  int          compares = 0;

  always #5 clock_in = ~clock_in;
  udc_host_model host (.clock_in, .token_out(token_in), .events_out(events_in));
  udc_ctrl i_dut (.*);

  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // w=0 reads and compares; data lands the edge after the strobe
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge clock_in);
    {cpu_cs_in, cpu_wr_in, cpu_rd_in, cpu_addr_in, cpu_wdata_in} = {1'b1, w, !w, a, d};
    @(negedge clock_in);
    {cpu_cs_in, cpu_wr_in, cpu_rd_in} = 3'b000;
    if (!w) check(cpu_rdata_out, d);
  endtask
  task automatic tok(input udc_tok_kind_t k, input udc_rsp_code_t c, input logic d);
    host.pulse({1'b1, k}, '0);
    check({10'h0, resp_out}, {10'h0, 1'b1, c, d});
  endtask

  initial begin
    #20000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    acc(1, 16'h4000, 16'h00fc);
    check({14'h0, usb_clock_gate_out, usb_pin_sel_out}, 16'h0003);
    for (int i = 2; i < 10; i += 2) acc(0, 16'h4000 + i[15:0], 16'h0000);
    acc(0, 16'h4020, 16'h0000);
    tok(UDC_TOK_IN_EP4, UDC_RSP_STALL, 1'b0);
    tok(UDC_TOK_OUT_EP3, UDC_RSP_STALL, 1'b1);
    tok(UDC_TOK_DESC, UDC_RSP_DATA, 1'b0);
    acc(1, 16'h4000, 16'h00c4);
    tok(UDC_TOK_IN_EP4, UDC_RSP_ZLP, 1'b0);
    tok(UDC_TOK_IN_EP4, UDC_RSP_NAK, 1'b0);
    acc(0, 16'h4000, 16'h0084);
    tok(UDC_TOK_DESC, UDC_RSP_NAK, 1'b0);
    tx_empty_in = 1'b0;
    tok(UDC_TOK_IN_EP4, UDC_RSP_DATA, 1'b0);
    acc(1, 16'h4002, 16'h00de);
    host.pulse('0, 8'hff);
    tok(UDC_TOK_OUT_EP3, UDC_RSP_NAK, 1'b1);
    acc(0, 16'h4004, 16'h00df);
    acc(0, 16'h4008, 16'h0002);
    check({15'h0, irq_out}, 16'h0001);
    acc(1, 16'h4004, 16'h0000);
    acc(0, 16'h4004, 16'h00df);
    acc(1, 16'h4004, 16'h00de);
    acc(0, 16'h4004, 16'h0001);
    check({15'h0, irq_out}, 16'h0000);
    acc(1, 16'h4006, 16'h0001);
    @(negedge clock_in);
    check({15'h0, irq_out}, 16'h0000);
    acc(1, 16'h4006, 16'h0002);
    @(negedge clock_in);
    check({15'h0, irq_out}, 16'h0001);
    acc(1, 16'h4008, 16'h0002);
    acc(0, 16'h4004, 16'h0000);
    check({15'h0, irq_out}, 16'h0000);
    // tx count off threshold, rx count on it: only the rx flag may set
    tx_count_in = 7'h04;
    rx_count_in = 7'h05;
    host.pulse('0, 8'h03);
    acc(0, 16'h4008, 16'h0001);
    check({15'h0, irq_out}, 16'h0000);
    acc(1, 16'h4006, 16'h0001);
    @(negedge clock_in);
    check({15'h0, irq_out}, 16'h0001);
    acc(1, 16'h4008, 16'h0001);
    acc(0, 16'h4004, 16'h0000);
    acc(1, 16'h4000, 16'h0004);
    check({14'h0, usb_clock_gate_out, usb_pin_sel_out}, 16'h0001);
    host.pulse({1'b1, UDC_TOK_OTHER}, '0);
    check({15'h0, resp_out.valid}, 16'h0000);
    give_verdict();
  end
endmodule
